// ===== src/srg_pkg.sv
package srg_pkg;
	localparam int unsigned STAGES    = 8;
	localparam int unsigned TAP_A     = 5;
	localparam int unsigned TAP_B     = 6;
	localparam int unsigned TAP_LAST  = 7;
	localparam int unsigned OUT_W     = 3;
	localparam int unsigned BUF_DEPTH = 2;
	localparam logic        ASYNC_LOAD_DEF = 1'b0;
	typedef enum logic [1:0]
	{
		SRG_IDLE  = 2'b00,
		SRG_SHIFT = 2'b01,
		SRG_LOAD  = 2'b10
	} srg_op_t;
endpackage

// ===== src/srg_buf_if.sv
`timescale 1ns/100ps
`default_nettype none
interface srg_buf_if;
	logic [srg_pkg::OUT_W-1:0] in_data;
	logic                      in_valid;
	logic                      in_ready;
	logic [srg_pkg::OUT_W-1:0] out_data;
	logic                      out_valid;
	logic                      out_ready;
	modport buffer
	(
		input  in_data,
		input  in_valid,
		output in_ready,
		output out_data,
		output out_valid,
		input  out_ready
	);
	modport user
	(
		output in_data,
		output in_valid,
		input  in_ready,
		input  out_data,
		input  out_valid,
		output out_ready
	);
endinterface
`default_nettype wire

// ===== src/srg_buf.sv
`timescale 1ns/100ps
`default_nettype none
module srg_buf
(
	// clock and reset
	input  wire logic  i_clk,
	input  wire logic  i_nrst,
	// stream
	srg_buf_if.buffer  bif
);
	// =====================================================
	// two-entry buffer
	logic [srg_pkg::OUT_W-1:0] mem_q [srg_pkg::BUF_DEPTH];
	logic [srg_pkg::OUT_W-1:0] mem_d [srg_pkg::BUF_DEPTH];
	logic                      wp_q, wp_d, rp_q, rp_d;
	logic [1:0]                cnt_q, cnt_d;
	logic                      push, pop;

	assign bif.in_ready  = (cnt_q != 2'h2);
	assign bif.out_valid = (cnt_q != 2'h0);
	assign bif.out_data  = mem_q[rp_q];

	always_comb
	begin
		push  = bif.in_valid && bif.in_ready;
		pop   = bif.out_valid && bif.out_ready;
		mem_d = mem_q;
		wp_d  = wp_q;
		rp_d  = rp_q;
		cnt_d = cnt_q;
		if (push)
		begin
			mem_d[wp_q] = bif.in_data;
			wp_d        = ~wp_q;
		end
		if (pop)
			rp_d = ~rp_q;
		if (push && !pop)
			cnt_d = cnt_q + 2'h1;
		else if (pop && !push)
			cnt_d = cnt_q - 2'h1;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'h0;
		end
		else
		begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
		mem_q <= mem_d;
	end

	a_buf_no_over:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		cnt_q <= 2'h2)
	else $error("buffer count out of range");
endmodule // srg_buf
`default_nettype wire

// ===== src/srg_top.sv
// Behaviour
// - eight stages, each loadable from the serial path or its own preset input.
// - each stage changes only on its clocking event, like an edge D flip-flop.
// - one shift clock, one load select, one serial input, one preset per stage.
// - stage 8 is the serial output, stages 6 and 7 are brought out too.
// - load select low, each rising shift clock edge shifts and takes serial in.
// - sync variant, load select high, each rising edge copies all presets.
// - async variant, presets load without a shift clock edge; shifting stays edged.
// - async variant, load select high forces stage clocking to take the presets.
// - instances cascade by feeding stage 8 output to the next serial input.
`timescale 1ns/100ps
`default_nettype none
module srg_top
#(
	parameter logic ASYNC_LOAD = srg_pkg::ASYNC_LOAD_DEF
)
(
	// clock and reset
	input  wire logic                      i_clk,
	input  wire logic                      i_nrst,
	// register pins
	input  wire logic                      i_shift_clock,
	input  wire logic                      i_load_sel,
	input  wire logic                      i_serial_in,
	input  wire logic [srg_pkg::STAGES-1:0] i_parallel_preset_inputs,
	// tap outputs
	output logic                           o_q6,
	output logic                           o_q7,
	output logic                           o_q8,
	// tap stream
	output logic [srg_pkg::OUT_W-1:0]      o_tap_data,
	output logic                           o_tap_valid,
	input  wire logic                      i_tap_ready,
	output logic                           o_overrun
);
	// =====================================================
	// pin synchronisers
	logic                      ck_m_q, ck_s_q, ck_p_q;
	logic                      ld_m_q, ld_s_q;
	logic                      si_m_q, si_s_q;
	logic [srg_pkg::STAGES-1:0] pp_m_q, pp_s_q;

	always_ff @(posedge i_clk)
	begin
		ck_m_q <= i_shift_clock;
		ck_s_q <= ck_m_q;
		ck_p_q <= ck_s_q;
		ld_m_q <= i_load_sel;
		ld_s_q <= ld_m_q;
		si_m_q <= i_serial_in;
		si_s_q <= si_m_q;
		pp_m_q <= i_parallel_preset_inputs;
		pp_s_q <= pp_m_q;
	end

	// =====================================================
	// operation select
	logic              rise;
	srg_pkg::srg_op_t  op;

	always_comb
	begin
		rise = ck_s_q && !ck_p_q;
		op   = srg_pkg::SRG_IDLE;
		if (ld_s_q && (ASYNC_LOAD || rise))
			op = srg_pkg::SRG_LOAD;
		else if (!ld_s_q && rise)
			op = srg_pkg::SRG_SHIFT;
	end

	// =====================================================
	// stage chain, not reset
	logic [srg_pkg::STAGES-1:0] stg_q, stg_d;

	generate
		for (genvar g = 0; g < srg_pkg::STAGES; g++)
		begin : g_stage
			always_comb
			begin
				case (op)
					srg_pkg::SRG_SHIFT:
						stg_d[g] = (g == 0) ? si_s_q
						                    : stg_q[(g == 0) ? 0 : g-1];
					srg_pkg::SRG_LOAD:
						stg_d[g] = pp_s_q[g];
					srg_pkg::SRG_IDLE:
						stg_d[g] = stg_q[g];
					default:
						stg_d[g] = stg_q[g];
				endcase
			end
		end
	endgenerate

	always_ff @(posedge i_clk)
	begin
		stg_q <= stg_d;
	end

	// =====================================================
	// tap outputs
	logic q6_q, q7_q, q8_q;
	logic q6_d, q7_d, q8_d;

	always_comb
	begin
		q6_d = stg_q[srg_pkg::TAP_A];
		q7_d = stg_q[srg_pkg::TAP_B];
		q8_d = stg_q[srg_pkg::TAP_LAST];
	end

	always_ff @(posedge i_clk)
	begin
		q6_q <= q6_d;
		q7_q <= q7_d;
		q8_q <= q8_d;
	end

	assign o_q6 = q6_q;
	assign o_q7 = q7_q;
	assign o_q8 = q8_q;

	// =====================================================
	// tap stream through two-entry buffer
	srg_buf_if bif ();
	logic      upd_q, upd_d, ovr_q, ovr_d;
	logic [srg_pkg::OUT_W-1:0] od_q;
	logic      ov_q;

	always_comb
	begin
		upd_d = (op != srg_pkg::SRG_IDLE);
		ovr_d = ovr_q | (upd_q & ~bif.in_ready);
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			upd_q <= 1'b0;
			ovr_q <= 1'b0;
		end
		else
		begin
			upd_q <= upd_d;
			ovr_q <= ovr_d;
		end
	end

	assign bif.in_valid  = upd_q;
	assign bif.in_data   = {q8_d, q7_d, q6_d};
	assign bif.out_ready = i_tap_ready || !ov_q;

	srg_buf u_buf
	(
		.i_clk  (i_clk),
		.i_nrst (i_nrst),
		.bif    (bif.buffer)
	);

	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
			ov_q <= 1'b0;
		else if (i_tap_ready || !ov_q)
			ov_q <= bif.out_valid;
		if (i_tap_ready || !ov_q)
			od_q <= bif.out_data;
	end

	assign o_tap_data  = od_q;
	assign o_tap_valid = ov_q;
	assign o_overrun   = ovr_q;

	// =====================================================
	// checks
	a_shift_moves_one:
	assert property (@(posedge i_clk)
		(op == srg_pkg::SRG_SHIFT) |=>
		stg_q[srg_pkg::STAGES-1:1] === $past(stg_q[srg_pkg::STAGES-2:0]))
	else $error("shift did not move stages");
	a_shift_takes_serial:
	assert property (@(posedge i_clk)
		(op == srg_pkg::SRG_SHIFT) |=> stg_q[0] === $past(si_s_q))
	else $error("serial input not captured");
	a_load_copies:
	assert property (@(posedge i_clk)
		(op == srg_pkg::SRG_LOAD) |=> stg_q == $past(pp_s_q))
	else $error("preset not loaded");
	a_async_load_forced:
	assert property (@(posedge i_clk)
		(ASYNC_LOAD && ld_s_q) |=> stg_q == $past(pp_s_q))
	else $error("async load not forced");
	a_hold_idle:
	assert property (@(posedge i_clk)
		(op == srg_pkg::SRG_IDLE) |=> stg_q === $past(stg_q))
	else $error("stages changed without event");
	a_edge_only:
	assert property (@(posedge i_clk)
		(!ld_s_q && !rise) |=> stg_q === $past(stg_q))
	else $error("stage changed without clock edge");
	a_tap_last:
	assert property (@(posedge i_clk)
		##1 o_q8 === $past(stg_q[srg_pkg::TAP_LAST]))
	else $error("stage 8 output wrong");
	a_tap_mid:
	assert property (@(posedge i_clk)
		##1 {o_q7, o_q6} ===
		$past({stg_q[srg_pkg::TAP_B], stg_q[srg_pkg::TAP_A]}))
	else $error("stage 6 or 7 output wrong");
	a_ovr_sticky:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_overrun |=> o_overrun)
	else $error("overrun flag dropped");
	a_tap_word_held:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		(o_tap_valid && !i_tap_ready) |=>
		(o_tap_valid && o_tap_data == $past(o_tap_data)))
	else $error("tap word not held while stalled");
endmodule // srg_top
`default_nettype wire

// ===== dv/srg_ext.sv
`timescale 1ns/100ps
`default_nettype none
module srg_ext
(
	// clock
	input  wire logic       i_clk,
	// register pins
	output logic            o_shift_clock,
	output logic            o_load_sel,
	output logic            o_serial_in,
	output logic [7:0]      o_preset
);
	// =========================================
	// pin drivers, all changed at falling edge
	initial
	begin
		o_shift_clock = 1'b0;
		o_load_sel = 1'b0;
		o_serial_in = 1'b0;
		o_preset = 8'h00;
	end
	// one edge, clock high and low four cycles each
	task automatic op(input logic l, input logic b, input logic [7:0] p);
		@(negedge i_clk);
		o_load_sel = l;
		o_serial_in = b;
		o_preset = p;
		@(negedge i_clk);
		o_shift_clock = 1'b1;
		repeat (4) @(negedge i_clk);
		o_shift_clock = 1'b0;
		repeat (4) @(negedge i_clk);
		o_load_sel = 1'b0;
	endtask
	// load select pulse with the shift clock kept still
	task automatic parallel_preset_inputs(input logic [7:0] p);
		@(negedge i_clk);
		o_preset = p;
		@(negedge i_clk);
		o_load_sel = 1'b1;
		repeat (4) @(negedge i_clk);
		o_load_sel = 1'b0;
		repeat (4) @(negedge i_clk);
	endtask
	// data pins change every cycle, no clock edge
	task automatic noise(input int n);
		repeat (n)
		begin
			@(negedge i_clk);
			o_serial_in = ~o_serial_in;
			o_preset = ~o_preset;
		end
	endtask
endmodule // srg_ext
`default_nettype wire

// ===== dv/srg_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module srg_top_tb_top;
	// =========================================
	// signals
	logic       i_clk = 1'b0;
	logic       i_nrst = 1'b0;
	logic       sck, ld, sin, q6, q7, q8, a6, a7, a8, tv, ov;
	logic       rdy = 1'b0;
	logic       stall = 1'b0;
	logic [7:0] pre, m, ma;
	logic [2:0] td;
	logic [2:0] exq[$];
	int         n_fail = 0;
	int         n_tests = 0;
	int         seed = 74284;
	always #2.5 i_clk = ~i_clk;
	srg_ext ext_u (.i_clk(i_clk), .o_shift_clock(sck), .o_load_sel(ld),
		.o_serial_in(sin), .o_preset(pre));
	srg_top dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_shift_clock(sck),
		.i_load_sel(ld), .i_serial_in(sin), .i_parallel_preset_inputs(pre),
		.o_q6(q6), .o_q7(q7), .o_q8(q8), .o_tap_data(td),
		.o_tap_valid(tv), .i_tap_ready(rdy), .o_overrun(ov));
	srg_top #(.ASYNC_LOAD(1'b1)) dut_a_u (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_shift_clock(sck), .i_load_sel(ld), .i_serial_in(sin),
		.i_parallel_preset_inputs(pre), .o_q6(a6), .o_q7(a7), .o_q8(a8),
		.o_tap_data(), .o_tap_valid(), .i_tap_ready(1'b1), .o_overrun());
	// =========================================
	// reference model and checks
	function automatic logic [7:0] nxt(logic [7:0] s, logic l, logic b,
		logic [7:0] p);
		return l ? p : {s[6:0], b};
	endfunction
	task automatic doop(logic l, logic b, logic [7:0] p);
		m = nxt(m, l, b, p);
		ma = nxt(ma, l, b, p);
		if (exq.size() < 3)
			exq.push_back(m[7:5]);
		ext_u.op(l, b, p);
		`CHK({q8, q7, q6}, m[7:5])
		`CHK({a8, a7, a6}, ma[7:5])
	endtask
	task automatic results;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// consumer with random stalls
	always @(negedge i_clk)
		rdy <= !stall && $random(seed);
	always @(posedge i_clk)
		if (tv === 1'b1 && rdy === 1'b1 && exq.size() > 0)
		begin
			`CHK(td, exq[0])
			exq.delete(0);
		end
	initial
	begin
		#(5 * 3000);
		n_fail++;
		results();
	end
	// =========================================
	// main sequence
	initial
	begin
		repeat (20) @(posedge i_clk);
		@(negedge i_clk) i_nrst = 1'b1;
		repeat (2) @(negedge i_clk);
		`CHK({tv, ov}, 2'b00)
		doop(1'b1, 1'b0, 8'hff);
		repeat (8) doop(1'b0, 1'b0, 8'hff);
		doop(1'b1, 1'b1, 8'h5a);
		repeat (24) doop(($random(seed) & 3) == 0, $random(seed),
			$random(seed));
		ext_u.noise(20);
		`CHK({q8, q7, q6}, m[7:5])
		ma = $random(seed);
		ext_u.parallel_preset_inputs(ma);
		`CHK({a8, a7, a6}, ma[7:5])
		`CHK({q8, q7, q6}, m[7:5])
		doop(1'b0, 1'b1, 8'h00);
		stall = 1'b1;
		repeat (4) doop(1'b0, $random(seed), 8'h00);
		`CHK(ov, 1'b1)
		stall = 1'b0;
		repeat (60) @(negedge i_clk);
		`CHK(exq.size() == 0, 1'b1)
		i_nrst = 1'b0;
		repeat (2) @(negedge i_clk);
		i_nrst = 1'b1;
		repeat (2) @(negedge i_clk);
		`CHK({ov, q8, q7, q6}, {1'b0, m[7:5]})
		results();
	end
endmodule // srg_top_tb_top
`default_nettype wire
